// file: vrc_reference_control.sv
// voltage reference control register with bias generator forcing
`timescale 1ns/1ps
`default_nettype none
`include "vrc_defs.svh"

// Summary of operation
// - bit 3 selects the reference source, zero for the external reference pin and one for the supply.
// - the bias generator enable is forced high while the converter, temperature sensor or oscillator is on.
// - writing one to bit 1 turns the bias generator on by itself, zero leaves it to the dependent peripherals.
// - bit 2 turns the temperature sensor on when set and off when cleared.
// - the sensor is routed to the highest-numbered code of the converter positive input multiplexer.
module vrc_reference_control (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire vrc_pkg::vrc_sfr_req_t sfr_req,
    output logic [7:0]                 sfr_rdata,
    input  wire logic                  adc_enable,
    input  wire logic                  osc_enable,
    input  wire logic [2:0]            adc_pos_mux_sel,
    output vrc_pkg::vrc_analog_t       analog_ctrl,
    output vrc_pkg::vrc_src_t          ref_source,
    output logic                       temp_sensor_selected
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] reference_control;
    logic [7:0] next_reference_control;
    logic       sel_hit;

    assign sel_hit = sfr_req.wr && (sfr_req.addr == `VRC_REF_CTRL_ADDR);

    always_comb begin
        next_reference_control = reference_control;
        if (sel_hit) begin
            next_reference_control = sfr_req.wdata & `VRC_WR_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reference_control <= `VRC_REF_CTRL_RESET;
        end else begin
            reference_control <= next_reference_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic bias_force;
    assign bias_force = adc_enable | osc_enable | reference_control[`VRC_BIT_TEMP_EN];

    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_req.addr == `VRC_REF_CTRL_ADDR) begin
            sfr_rdata = reference_control & `VRC_WR_MASK;
            sfr_rdata[`VRC_BIT_BIAS_EN] = reference_control[`VRC_BIT_BIAS_EN] | bias_force;
        end
    end

    always_comb begin
        analog_ctrl.ref_source_select  = reference_control[`VRC_BIT_REF_SEL];
        analog_ctrl.temp_sensor_enable = reference_control[`VRC_BIT_TEMP_EN];
        analog_ctrl.bias_gen_enable    = reference_control[`VRC_BIT_BIAS_EN] | bias_force;
    end

    assign ref_source = reference_control[`VRC_BIT_REF_SEL] ? vrc_pkg::VRC_SRC_SUPPLY
                                                           : vrc_pkg::VRC_SRC_EXT_PIN;
    assign temp_sensor_selected = (adc_pos_mux_sel == `VRC_TEMP_MUX_CODE) && reference_control[`VRC_BIT_TEMP_EN];

    ////////////////////////////////////////////////////////////////////////////
    // decoded from the bus itself so that a broken internal decode cannot hide behind its own signal
    sequence s_ctrl_write;
        sfr_req.wr && (sfr_req.addr == `VRC_REF_CTRL_ADDR);
    endsequence

    sequence s_no_ctrl_write;
        !(sfr_req.wr && (sfr_req.addr == `VRC_REF_CTRL_ADDR));
    endsequence

    sequence s_foreign_write;
        sfr_req.wr && (sfr_req.addr != `VRC_REF_CTRL_ADDR);
    endsequence

    sequence s_write_bias_on;
        sfr_req.wr && (sfr_req.addr == `VRC_REF_CTRL_ADDR) && sfr_req.wdata[`VRC_BIT_BIAS_EN];
    endsequence

    sequence s_write_bias_off;
        sfr_req.wr && (sfr_req.addr == `VRC_REF_CTRL_ADDR)
            && !sfr_req.wdata[`VRC_BIT_BIAS_EN] && !sfr_req.wdata[`VRC_BIT_TEMP_EN];
    endsequence

    sequence s_no_dependents;
        !adc_enable && !osc_enable;
    endsequence

    sequence s_ctrl_read;
        sfr_req.addr == `VRC_REF_CTRL_ADDR;
    endsequence

    sequence s_sensor_code;
        adc_pos_mux_sel == `VRC_TEMP_MUX_CODE;
    endsequence

    property p_write_stores;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |=> (reference_control == ($past(sfr_req.wdata) & `VRC_WR_MASK));
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("control register did not take write");

    property p_ref_source_map;
        @(posedge clk) disable iff (rst)
            analog_ctrl.ref_source_select == (ref_source == vrc_pkg::VRC_SRC_SUPPLY);
    endproperty
    a_ref_source_map: assert property (p_ref_source_map)
        else $error("reference source mismatch");

    property p_ref_source_write;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |=> ((ref_source == vrc_pkg::VRC_SRC_SUPPLY) == $past(sfr_req.wdata[`VRC_BIT_REF_SEL]));
    endproperty
    a_ref_source_write: assert property (p_ref_source_write)
        else $error("reference source does not follow write");

    property p_bias_forced;
        @(posedge clk) disable iff (rst)
            (adc_enable || osc_enable || analog_ctrl.temp_sensor_enable) |-> analog_ctrl.bias_gen_enable;
    endproperty
    a_bias_forced: assert property (p_bias_forced)
        else $error("bias generator not forced on");

    property p_bias_manual;
        @(posedge clk) disable iff (rst)
            s_write_bias_on |=> analog_ctrl.bias_gen_enable;
    endproperty
    a_bias_manual: assert property (p_bias_manual)
        else $error("manual bias enable ignored");

    property p_bias_off;
        @(posedge clk) disable iff (rst)
            s_write_bias_off ##1 s_no_dependents |-> !analog_ctrl.bias_gen_enable;
    endproperty
    a_bias_off: assert property (p_bias_off)
        else $error("bias generator on without cause");

    property p_bias_cause;
        @(posedge clk) disable iff (rst)
            analog_ctrl.bias_gen_enable |-> (reference_control[`VRC_BIT_BIAS_EN] || adc_enable || osc_enable
                                             || analog_ctrl.temp_sensor_enable);
    endproperty
    a_bias_cause: assert property (p_bias_cause)
        else $error("bias generator on with no source");

    property p_temp_enable;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |=> (analog_ctrl.temp_sensor_enable == $past(sfr_req.wdata[`VRC_BIT_TEMP_EN]));
    endproperty
    a_temp_enable: assert property (p_temp_enable)
        else $error("sensor enable wrong");

    property p_temp_route;
        @(posedge clk) disable iff (rst)
            temp_sensor_selected |-> (adc_pos_mux_sel == `VRC_TEMP_MUX_CODE && analog_ctrl.temp_sensor_enable);
    endproperty
    a_temp_route: assert property (p_temp_route)
        else $error("sensor routed on wrong code");

    property p_temp_route_on;
        @(posedge clk) disable iff (rst)
            s_sensor_code |-> (temp_sensor_selected == analog_ctrl.temp_sensor_enable);
    endproperty
    a_temp_route_on: assert property (p_temp_route_on)
        else $error("sensor not routed on top code");

    property p_sensor_off;
        @(posedge clk) disable iff (rst)
            !analog_ctrl.temp_sensor_enable |-> !temp_sensor_selected;
    endproperty
    a_sensor_off: assert property (p_sensor_off)
        else $error("disabled sensor presented to converter");

    property p_unused_zero;
        @(posedge clk) disable iff (rst)
            (sfr_rdata & `VRC_UNUSED_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read nonzero");

    property p_read_other;
        @(posedge clk) disable iff (rst)
            (sfr_req.addr != `VRC_REF_CTRL_ADDR) |-> (sfr_rdata == 8'h00);
    endproperty
    a_read_other: assert property (p_read_other)
        else $error("read data on foreign address");

    property p_read_mirror;
        @(posedge clk) disable iff (rst)
            s_ctrl_read |-> (sfr_rdata[`VRC_BIT_REF_SEL] == analog_ctrl.ref_source_select
                             && sfr_rdata[`VRC_BIT_TEMP_EN] == analog_ctrl.temp_sensor_enable);
    endproperty
    a_read_mirror: assert property (p_read_mirror)
        else $error("readback differs from controls");

    property p_read_bias;
        @(posedge clk) disable iff (rst)
            s_ctrl_read |-> (sfr_rdata[`VRC_BIT_BIAS_EN] == analog_ctrl.bias_gen_enable);
    endproperty
    a_read_bias: assert property (p_read_bias)
        else $error("bias readback differs from enable");

    property p_write_readback;
        @(posedge clk) disable iff (rst)
            s_ctrl_write ##1 s_ctrl_read |-> (sfr_rdata[`VRC_BIT_REF_SEL] == $past(sfr_req.wdata[`VRC_BIT_REF_SEL])
                                              && sfr_rdata[`VRC_BIT_TEMP_EN] == $past(sfr_req.wdata[`VRC_BIT_TEMP_EN]));
    endproperty
    a_write_readback: assert property (p_write_readback)
        else $error("written bits not read back");

    property p_reset_clear;
        @(posedge clk) rst |=> (reference_control == `VRC_REF_CTRL_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("register not cleared by reset");

    property p_foreign_ignored;
        @(posedge clk) disable iff (rst)
            s_foreign_write |=> $stable(reference_control);
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored)
        else $error("foreign write changed register");

    property p_idle_hold;
        @(posedge clk) disable iff (rst)
            s_no_ctrl_write |=> $stable(reference_control);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("register changed without write");

endmodule // vrc_reference_control
`default_nettype wire

// file: vrc_defs.svh
// register offset, field positions and reset value of the voltage reference control
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH
`define VRC_REF_CTRL_ADDR   8'hD1
`define VRC_REF_CTRL_RESET  8'h00
`define VRC_BIT_REF_SEL     3
`define VRC_BIT_TEMP_EN     2
`define VRC_BIT_BIAS_EN     1
`define VRC_WR_MASK         8'h0E
`define VRC_UNUSED_MASK     8'hF1
`define VRC_TEMP_MUX_CODE   3'h7
`endif

// file: vrc_pkg.sv
// types of the voltage reference control
`default_nettype none
package vrc_pkg;
    // special function register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
    } vrc_sfr_req_t;

    // analog control outputs
    typedef struct packed {
        logic ref_source_select;
        logic temp_sensor_enable;
        logic bias_gen_enable;
    } vrc_analog_t;

    typedef enum logic {
        VRC_SRC_EXT_PIN,
        VRC_SRC_SUPPLY
    } vrc_src_t;
endpackage
`default_nettype wire

// file: voltage_reference_control_bench.sv
// self-checking bench for the voltage reference control register
`timescale 1ns/1ps
`default_nettype none
`include "vrc_defs.svh"

module voltage_reference_control_bench;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    vrc_pkg::vrc_sfr_req_t req = '0;
    logic                  adc = 1'b0;
    logic                  osc = 1'b0;
    logic [2:0]            mux = 3'h0;
    logic [7:0]            rdata;
    vrc_pkg::vrc_analog_t  ac;
    vrc_pkg::vrc_src_t     src;
    logic                  tsel;
    logic [3:1]            m = 3'h0;
    logic [31:0]           r;
    logic [7:0]            corner [3] = '{8'hFF, 8'h02, 8'h00};
    int                    failures = 0;
    int                    compares = 0;

    always #2 clk = ~clk;

    vrc_reference_control dut (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .adc_enable(adc),
        .osc_enable(osc), .adc_pos_mux_sel(mux), .analog_ctrl(ac), .ref_source(src), .temp_sensor_selected(tsel));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic check_all;
        logic b;
        b = m[1] | adc | osc | m[2];
        chk(rdata, (req.addr == `VRC_REF_CTRL_ADDR) ? {4'h0, m[3:2], b, 1'b0} : 8'h00);
        chk({5'h00, ac}, {5'h00, m[3:2], b});
        chk({7'h00, src}, {7'h00, m[3]});
        chk({7'h00, tsel}, {7'h00, m[2] && mux == `VRC_TEMP_MUX_CODE});
    endtask

    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(49));
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check_all;
        $display("reset test done");
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            if (req.wr && req.addr == `VRC_REF_CTRL_ADDR) m = req.wdata[3:1];
            check_all;
            r = $urandom;
            if (i < 3) r = {15'h0000, 1'b1, 8'h00, corner[i]};
            req = {(i % 4 == 3) ? r[31:24] : `VRC_REF_CTRL_ADDR, r[7:0], r[16]};
            {mux, osc, adc} = r[21:17];
        end
        $display("random test done");
        @(negedge clk);
        if (req.wr && req.addr == `VRC_REF_CTRL_ADDR) m = req.wdata[3:1];
        check_all;
        req = {`VRC_REF_CTRL_ADDR, 8'hFF, 1'b1};
        {mux, osc, adc} = 5'h1C;
        @(negedge clk);
        m = 3'h7;
        check_all;
        rst = 1'b1;
        req = {`VRC_REF_CTRL_ADDR, 8'hFF, 1'b0};
        m = 3'h0;
        repeat (2) @(negedge clk);
        check_all;
        rst = 1'b0;
        req = {`VRC_REF_CTRL_ADDR, 8'h08, 1'b1};
        @(negedge clk);
        m = 3'h4;
        check_all;
        req = '0;
        $display("mid-run reset test done");
        end_sim;
    end

    initial begin
        #4000;
        failures++;
        end_sim;
    end
endmodule // voltage_reference_control_bench
`default_nettype wire
